// ==== outcfg_pkg.sv ====
// Package with register map, field layout and carrier types for the output configuration block
package outcfg_pkg;
    // Register offsets
    localparam logic [15:0] driver_c_config_addr = 16'h10d9;
    localparam logic [15:0] secondary_clock_path_addr = 16'h10da;
    // Field positions in driver_c_config
    localparam int drv_hcsl_bit = 0;
    localparam int drv_level_lo = 1;
    localparam int drv_mode_lo = 3;
    localparam int drv_bypass_bit = 5;
    // Field positions in secondary_clock_path
    localparam int sec_sync_mask_bit = 0;
    localparam int sec_first_bit = 1;
    localparam int sec_second_bit = 2;
    localparam int sec_third_bit = 3;
    // Writable bit masks and reset value
    localparam logic [7:0] driver_c_wmask = 8'h3f;
    localparam logic [7:0] secondary_wmask = 8'h0f;
    localparam logic [7:0] cfg_reset = 8'h00;
    // Driver mode codes
    localparam logic [1:0] mode_diff = 2'h0;
    localparam logic [1:0] mode_se_first = 2'h1;
    localparam logic [1:0] mode_se_split = 2'h2;
    // Drive level codes; the fourth code is not a valid level
    localparam logic [1:0] level_low = 2'h0;
    localparam logic [1:0] level_mid = 2'h1;
    localparam logic [1:0] level_high = 2'h2;

    // Register bus request
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    // Driver controls for the third output pair
    typedef struct packed {
        logic true_from_first;   // True pin driven by first_dist_divider
        logic comp_from_first;   // Complement pin driven by first_dist_divider
        logic comp_divider_en;   // third_complement_divider enabled
        logic differential;      // Pair driven differentially
        logic [1:0] level;       // Current code for both pins
        logic hcsl;              // 1 current source, 0 current sink
        logic mute;              // Effective mute to the driver
        logic out_enable;        // Driver may toggle
    } drv_ctrl_t;

    // Secondary clock path controls
    typedef struct packed {
        logic system_clock_to_first;
        logic system_clock_to_second;
        logic system_clock_to_third;
        logic sync_first;
        logic sync_second;
        logic sync_third;
    } clk_ctrl_t;
endpackage

// ==== output_driver_and_secondary_clock_cfg.sv ====
// Driver C configuration, secondary clock path and system-clock sync masking
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps

module output_driver_and_secondary_clock_cfg (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic sync_event,
    input wire logic mute_req,
    input wire logic third_div_edge,
    output outcfg_pkg::drv_ctrl_t drv_ctrl,
    output outcfg_pkg::clk_ctrl_t clk_ctrl
);
    // Complete module state
    typedef struct packed {
        logic [7:0] drv_cfg;
        logic [7:0] sec_cfg;
        logic [7:0] rdata;
        logic synced;
        logic mute_retimed;
        outcfg_pkg::drv_ctrl_t drv;
        outcfg_pkg::clk_ctrl_t clk;
    } state_t;

    state_t st;
    state_t next_st;
    outcfg_pkg::bus_req_t req;

    // Read mux, used for read data
    function automatic logic [7:0] reg_read(input logic [15:0] a, input logic [7:0] d,
                                            input logic [7:0] s);
        if (a == outcfg_pkg::driver_c_config_addr) begin
            reg_read = d;
        end else if (a == outcfg_pkg::secondary_clock_path_addr) begin
            reg_read = s;
        end else begin
            reg_read = 8'h00;
        end
    endfunction

    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    // Next-state logic
    always_comb begin
        logic [1:0] mode;
        logic bypass;
        logic sys_first;
        logic sys_second;
        logic sys_third;
        logic mask;
        mode = 2'h0;
        bypass = 1'b0;
        sys_first = 1'b0;
        sys_second = 1'b0;
        sys_third = 1'b0;
        mask = 1'b0;
        next_st = st;
        // Register writes keep only writable bits
        if (req.wr && req.addr == outcfg_pkg::driver_c_config_addr) begin
            next_st.drv_cfg = req.wdata & outcfg_pkg::driver_c_wmask;
        end
        if (req.wr && req.addr == outcfg_pkg::secondary_clock_path_addr) begin
            next_st.sec_cfg = req.wdata & outcfg_pkg::secondary_wmask;
        end
        // Read data valid only the cycle after the strobe
        next_st.rdata = req.rd ? reg_read(req.addr, st.drv_cfg, st.sec_cfg) : 8'h00;

        mode = st.drv_cfg[outcfg_pkg::drv_mode_lo +: 2];
        bypass = st.drv_cfg[outcfg_pkg::drv_bypass_bit];
        sys_first = st.sec_cfg[outcfg_pkg::sec_first_bit];
        sys_second = st.sec_cfg[outcfg_pkg::sec_second_bit];
        sys_third = st.sec_cfg[outcfg_pkg::sec_third_bit];
        mask = st.sec_cfg[outcfg_pkg::sec_sync_mask_bit];

        // Drivers stay static until the first sync arrives
        if (sync_event) begin
            next_st.synced = 1'b1;
        end
        next_st.drv.out_enable = st.synced;

        // Mode decode
        next_st.drv.differential = (mode == outcfg_pkg::mode_diff);
        next_st.drv.true_from_first = (mode == outcfg_pkg::mode_se_first);
        next_st.drv.comp_from_first = (mode == outcfg_pkg::mode_se_first);
        next_st.drv.comp_divider_en = (mode == outcfg_pkg::mode_se_split);
        next_st.drv.level = st.drv_cfg[outcfg_pkg::drv_level_lo +: 2];
        next_st.drv.hcsl = st.drv_cfg[outcfg_pkg::drv_hcsl_bit];

        // Mute retimed on divider edge unless bypassed
        if (third_div_edge) begin
            next_st.mute_retimed = mute_req;
        end
        next_st.drv.mute = bypass ? mute_req : next_st.mute_retimed;

        // System clock routing
        next_st.clk.system_clock_to_first = sys_first;
        next_st.clk.system_clock_to_second = sys_second;
        next_st.clk.system_clock_to_third = sys_third;
        // Sync events blocked on system-clock outputs when masked
        next_st.clk.sync_first = sync_event && !(mask && sys_first);
        next_st.clk.sync_second = sync_event && !(mask && sys_second);
        next_st.clk.sync_third = sync_event && !(mask && sys_third);

        if (reset) begin
            next_st = '0;
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        st <= next_st;
    end

    // Outputs straight from flip-flops
    assign rdata = st.rdata;
    assign drv_ctrl = st.drv;
    assign clk_ctrl = st.clk;

    // Register bus checks
    property p_wr_drv;
        @(posedge sys_clk) disable iff (reset)
        wr && addr == outcfg_pkg::driver_c_config_addr
        |=> st.drv_cfg == ($past(wdata) & outcfg_pkg::driver_c_wmask);
    endproperty
    a_wr_drv: assert property (p_wr_drv) else $error("driver config write lost");

    property p_wr_sec;
        @(posedge sys_clk) disable iff (reset)
        wr && addr == outcfg_pkg::secondary_clock_path_addr
        |=> st.sec_cfg == ($past(wdata) & outcfg_pkg::secondary_wmask);
    endproperty
    a_wr_sec: assert property (p_wr_sec) else $error("secondary config write lost");

    property p_wr_unmapped;
        @(posedge sys_clk) disable iff (reset)
        wr && addr != outcfg_pkg::driver_c_config_addr
        && addr != outcfg_pkg::secondary_clock_path_addr |=> $stable(st.drv_cfg) && $stable(st.sec_cfg);
    endproperty
    a_wr_unmapped: assert property (p_wr_unmapped) else $error("unmapped write landed");

    property p_reserved;
        @(posedge sys_clk) disable iff (reset)
        1'b1 |-> (st.drv_cfg & ~outcfg_pkg::driver_c_wmask) == 8'h00
            && (st.sec_cfg & ~outcfg_pkg::secondary_wmask) == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits stored");

    property p_rd_drv;
        @(posedge sys_clk) disable iff (reset)
        rd && addr == outcfg_pkg::driver_c_config_addr |=> rdata == $past(st.drv_cfg);
    endproperty
    a_rd_drv: assert property (p_rd_drv) else $error("driver config read wrong");

    property p_rd_zero_reserved;
        @(posedge sys_clk) disable iff (reset)
        rd && addr == outcfg_pkg::secondary_clock_path_addr |=> rdata[7:4] == 4'h0;
    endproperty
    a_rd_zero_reserved: assert property (p_rd_zero_reserved) else $error("reserved bits set");

    property p_rd_unmapped;
        @(posedge sys_clk) disable iff (reset)
        rd && addr != outcfg_pkg::driver_c_config_addr
        && addr != outcfg_pkg::secondary_clock_path_addr |=> rdata == 8'h00;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

    property p_rd_idle;
        @(posedge sys_clk) disable iff (reset)
        !rd |=> rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");

    // Driver mode decode
    property p_diff;
        @(posedge sys_clk) disable iff (reset)
        st.drv_cfg[outcfg_pkg::drv_mode_lo +: 2] == outcfg_pkg::mode_diff |=> drv_ctrl.differential;
    endproperty
    a_diff: assert property (p_diff) else $error("differential mode wrong");

    property p_se_first;
        @(posedge sys_clk) disable iff (reset)
        st.drv_cfg[outcfg_pkg::drv_mode_lo +: 2] == outcfg_pkg::mode_se_first
        |=> drv_ctrl.true_from_first && drv_ctrl.comp_from_first && !drv_ctrl.differential;
    endproperty
    a_se_first: assert property (p_se_first) else $error("single-ended source wrong");

    property p_split;
        @(posedge sys_clk) disable iff (reset)
        st.drv_cfg[outcfg_pkg::drv_mode_lo +: 2] == outcfg_pkg::mode_se_split
        |=> drv_ctrl.comp_divider_en && !drv_ctrl.differential && !drv_ctrl.true_from_first;
    endproperty
    a_split: assert property (p_split) else $error("complement divider off");

    property p_mode_unused;
        @(posedge sys_clk) disable iff (reset)
        st.drv_cfg[outcfg_pkg::drv_mode_lo +: 2] == 2'h3
        |=> !drv_ctrl.differential && !drv_ctrl.true_from_first && !drv_ctrl.comp_divider_en;
    endproperty
    a_mode_unused: assert property (p_mode_unused) else $error("unused mode decoded");

    property p_level;
        @(posedge sys_clk) disable iff (reset)
        1'b1 |=> drv_ctrl.level == $past(st.drv_cfg[outcfg_pkg::drv_level_lo +: 2])
            && drv_ctrl.hcsl == $past(st.drv_cfg[outcfg_pkg::drv_hcsl_bit]);
    endproperty
    a_level: assert property (p_level) else $error("level or style wrong");

    // Mute retiming
    property p_bypass;
        @(posedge sys_clk) disable iff (reset)
        st.drv_cfg[outcfg_pkg::drv_bypass_bit] && mute_req |=> drv_ctrl.mute;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass mute not immediate");

    property p_bypass_release;
        @(posedge sys_clk) disable iff (reset)
        st.drv_cfg[outcfg_pkg::drv_bypass_bit] && !mute_req |=> !drv_ctrl.mute;
    endproperty
    a_bypass_release: assert property (p_bypass_release) else $error("bypass unmute late");

    property p_retime_edge;
        @(posedge sys_clk) disable iff (reset)
        !st.drv_cfg[outcfg_pkg::drv_bypass_bit] && third_div_edge
        |=> drv_ctrl.mute == $past(mute_req);
    endproperty
    a_retime_edge: assert property (p_retime_edge) else $error("mute not taken on edge");

    property p_retime_hold;
        @(posedge sys_clk) disable iff (reset)
        !st.drv_cfg[outcfg_pkg::drv_bypass_bit] && !third_div_edge
        |=> drv_ctrl.mute == $past(st.mute_retimed);
    endproperty
    a_retime_hold: assert property (p_retime_hold) else $error("mute moved between edges");

    // Secondary clock path and sync masking
    property p_route;
        @(posedge sys_clk) disable iff (reset)
        1'b1 |=> clk_ctrl.system_clock_to_third == $past(st.sec_cfg[outcfg_pkg::sec_third_bit])
            && clk_ctrl.system_clock_to_second == $past(st.sec_cfg[outcfg_pkg::sec_second_bit])
            && clk_ctrl.system_clock_to_first == $past(st.sec_cfg[outcfg_pkg::sec_first_bit]);
    endproperty
    a_route: assert property (p_route) else $error("clock routing wrong");

    property p_mask;
        @(posedge sys_clk) disable iff (reset)
        st.sec_cfg[outcfg_pkg::sec_sync_mask_bit] && st.sec_cfg[outcfg_pkg::sec_second_bit]
        |=> !clk_ctrl.sync_second;
    endproperty
    a_mask: assert property (p_mask) else $error("masked sync leaked");

    property p_mask_first;
        @(posedge sys_clk) disable iff (reset)
        st.sec_cfg[outcfg_pkg::sec_sync_mask_bit] && st.sec_cfg[outcfg_pkg::sec_first_bit]
        |=> !clk_ctrl.sync_first;
    endproperty
    a_mask_first: assert property (p_mask_first) else $error("masked sync leaked first");

    property p_mask_third;
        @(posedge sys_clk) disable iff (reset)
        st.sec_cfg[outcfg_pkg::sec_sync_mask_bit] && st.sec_cfg[outcfg_pkg::sec_third_bit]
        |=> !clk_ctrl.sync_third;
    endproperty
    a_mask_third: assert property (p_mask_third) else $error("masked sync leaked third");

    property p_sync_pass;
        @(posedge sys_clk) disable iff (reset)
        sync_event && !st.sec_cfg[outcfg_pkg::sec_sync_mask_bit]
        |=> clk_ctrl.sync_first && clk_ctrl.sync_second && clk_ctrl.sync_third;
    endproperty
    a_sync_pass: assert property (p_sync_pass) else $error("unmasked sync dropped");

    property p_no_sync;
        @(posedge sys_clk) disable iff (reset)
        !sync_event |=> !clk_ctrl.sync_first && !clk_ctrl.sync_second && !clk_ctrl.sync_third;
    endproperty
    a_no_sync: assert property (p_no_sync) else $error("sync pulse without event");

    // Drivers held static until the first sync
    property p_sync_latch;
        @(posedge sys_clk) disable iff (reset)
        sync_event |=> st.synced;
    endproperty
    a_sync_latch: assert property (p_sync_latch) else $error("sync event not recorded");

    property p_static;
        @(posedge sys_clk) disable iff (reset)
        !st.synced |=> !drv_ctrl.out_enable;
    endproperty
    a_static: assert property (p_static) else $error("driver enabled before sync");

    property p_enable;
        @(posedge sys_clk) disable iff (reset)
        st.synced |=> drv_ctrl.out_enable;
    endproperty
    a_enable: assert property (p_enable) else $error("driver not enabled after sync");

    // Main scenarios
    c_sync: cover property (@(posedge sys_clk) disable iff (reset) sync_event ##1 st.synced);
    c_split: cover property (@(posedge sys_clk) disable iff (reset) drv_ctrl.comp_divider_en);
    c_masked: cover property (@(posedge sys_clk) disable iff (reset)
        sync_event && st.sec_cfg[0] && st.sec_cfg[1]);
    c_bypass: cover property (@(posedge sys_clk) disable iff (reset)
        st.drv_cfg[outcfg_pkg::drv_bypass_bit] && mute_req);
endmodule

// ==== output_driver_and_secondary_clock_cfg_test.sv ====
// Self-checking testbench for the output driver and secondary clock configuration block
`timescale 1ns/1ps
module output_driver_and_secondary_clock_cfg_test;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic sync_event = 1'b0;
    logic mute_req = 1'b0;
    logic third_div_edge = 1'b0;
    logic [7:0] rdata;
    outcfg_pkg::drv_ctrl_t drv_ctrl;
    outcfg_pkg::clk_ctrl_t clk_ctrl;
    int fails = 0;
    int n_compared = 0;
    localparam logic [15:0] drv_a = outcfg_pkg::driver_c_config_addr;
    localparam logic [15:0] sec_a = outcfg_pkg::secondary_clock_path_addr;

    output_driver_and_secondary_clock_cfg output_driver_and_secondary_clock_cfg_i (
        .sys_clk(sys_clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .sync_event(sync_event), .mute_req(mute_req),
        .third_div_edge(third_div_edge), .drv_ctrl(drv_ctrl), .clk_ctrl(clk_ctrl)
    );

    // Clock of 8 ns period
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    // Compare and count
    task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Wait edges, then let updates settle
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // One-cycle register write
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask

    // One-cycle register read, data taken in the following cycle
    task automatic rd_reg(input logic [15:0] a, input logic [7:0] e, input string n);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        chk(n, {1'b0, rdata}, {1'b0, e});
    endtask

    // Reset values, unmapped read, driver held static
    task automatic t_reset();
        rd_reg(drv_a, 8'h00, "driver reset");
        rd_reg(sec_a, 8'h00, "secondary reset");
        rd_reg(16'h10db, 8'h00, "unmapped read");
        chk("out_enable before sync", {8'h00, drv_ctrl.out_enable}, 9'h000);
        $display("test reset done");
    endtask

    // Reserved bits dropped, unmapped write ignored
    task automatic t_regs();
        wr_reg(drv_a, 8'hff);
        wr_reg(sec_a, 8'hff);
        wr_reg(16'h10db, 8'h00);
        rd_reg(drv_a, 8'h3f, "driver writable");
        rd_reg(sec_a, 8'h0f, "secondary writable");
        $display("test regs done");
    endtask

    // Each driver mode with level and termination
    task automatic t_modes();
        logic [1:0] m;
        for (int i = 0; i < 3; i++) begin
            m = i[1:0];
            wr_reg(drv_a, {3'h0, m, m, m[0]});
            tick(1);
            chk("mode", {5'h00, drv_ctrl[8:5]}, {5'h00, m == 2'h1, m == 2'h1, m == 2'h2,
                m == 2'h0});
            chk("level", {7'h00, drv_ctrl.level}, {7'h00, m});
            chk("hcsl", {8'h00, drv_ctrl.hcsl}, {8'h00, m[0]});
        end
        $display("test modes done");
    endtask

    // Clock routing and masked sync events
    task automatic t_sync();
        logic [7:0] cfg [3] = '{8'h0f, 8'h03, 8'h00};
        logic [2:0] route [3] = '{3'h7, 3'h4, 3'h0};
        logic [2:0] pass [3] = '{3'h0, 3'h3, 3'h7};
        logic [2:0] seen;
        for (int i = 0; i < 3; i++) begin
            wr_reg(sec_a, cfg[i]);
            tick(1);
            chk("routing", {6'h00, clk_ctrl[5:3]}, {6'h00, route[i]});
            @(posedge sys_clk);
            sync_event <= 1'b1;
            @(posedge sys_clk);
            sync_event <= 1'b0;
            #1;
            seen = clk_ctrl[2:0];
            repeat (3) begin
                tick(1);
                seen = seen | clk_ctrl[2:0];
            end
            chk("sync pulses", {6'h00, seen}, {6'h00, pass[i]});
            chk("out_enable after sync", {8'h00, drv_ctrl.out_enable}, 9'h001);
        end
        $display("test sync done");
    endtask

    // Retimed mute waits for a divider edge, bypassed mute follows at once
    task automatic t_mute();
        wr_reg(drv_a, 8'h00);
        @(posedge sys_clk);
        mute_req <= 1'b1;
        tick(3);
        chk("mute before edge", {8'h00, drv_ctrl.mute}, 9'h000);
        @(posedge sys_clk);
        third_div_edge <= 1'b1;
        @(posedge sys_clk);
        third_div_edge <= 1'b0;
        tick(1);
        chk("mute after edge", {8'h00, drv_ctrl.mute}, 9'h001);
        wr_reg(drv_a, 8'h20);
        @(posedge sys_clk);
        mute_req <= 1'b0;
        tick(2);
        chk("mute bypassed", {8'h00, drv_ctrl.mute}, 9'h000);
        $display("test mute done");
    endtask

    // Counts and verdict, then end the run
    task automatic summarize();
        $display("compared %0d mismatched %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset();
        t_regs();
        t_modes();
        t_sync();
        t_mute();
        summarize();
    end

    // Watchdog well beyond the roughly 83 cycles the tests need
    initial begin
        repeat (3000) @(posedge sys_clk);
        fails++;
        summarize();
    end
endmodule
